// ==== hw/aab_pkg.sv ====
package aab_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_CYCLES = 8'h14;
    localparam logic [7:0] OFF_PROBE = 8'h18;

    localparam int CTRL_OVM_BIT = 0;
    localparam int CTRL_SXM_BIT = 1;
    localparam int CTRL_WS_LSB = 8;
    localparam int WS_W = 4;

    localparam int STAT_C_BIT = 0;
    localparam int STAT_OV_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_REFUSED_BIT = 3;
    localparam int STAT_BADOP_BIT = 4;
    localparam int STAT_PA_IN_BIT = 8;
    localparam int STAT_PB_IN_BIT = 9;
    localparam int STAT_CONFLICT_BIT = 10;

    localparam int CMD_READ_BIT = 16;
    localparam int CMD_WRITE_BIT = 17;
    localparam int CMD_CODE_EXT_BIT = 18;
    localparam int CMD_RPT_LSB = 24;

    // ****************************************************************
    // Operation constants
    // ****************************************************************
    localparam logic [15:0] ABS_OPCODE = 16'hBE00;
    localparam logic [31:0] ACC_MOST_NEG = 32'h8000_0000;
    localparam logic [31:0] ACC_MOST_POS = 32'h7FFF_FFFF;
    localparam logic [15:0] SINGLE_ACCESS_RAM_BASE = 16'h0800;
    localparam int SINGLE_ACCESS_RAM_BLK_SHIFT = 11;
    localparam int SINGLE_ACCESS_RAM_BLOCKS = 4;
    localparam logic [7:0] RPT_MIN = 8'h03;
    localparam logic [15:0] EXT_READ_BASE = 16'h0001;
    localparam logic [15:0] EXT_WRITE_BASE = 16'h0002;
    localparam logic [15:0] EXT_WRITE_TURN = 16'h0003;

    localparam logic [1:0] KIND_ABS = 2'h0;
    localparam logic [1:0] KIND_READ = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_RUN = 2'b10
    } aab_engine_type;

    typedef struct packed {
        aab_engine_type eng;
        logic [31:0] acc;
        logic carry;
        logic ov;
        logic saturate_on_overflow_mode;
        logic sign_extend_mode;
        logic [WS_W-1:0] ws;
        logic refused;
        logic badop;
        logic [15:0] pc;
        logic [1:0] kind;
        logic code_ext;
        logic [15:0] cnt;
        logic [15:0] elapsed;
        logic [15:0] waits;
        logic [15:0] last_cycles;
        logic [15:0] last_waits;
        logic last_was_read;
        logic turn_write;
        logic [31:0] src;
        logic [15:0] src_pc;
        logic done_abs;
        logic done_ext;
        logic [31:0] probe;
        logic pa_in;
        logic pb_in;
        logic conflict;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } aab_state_type;

endpackage

// ==== hw/aab_core.sv ====
module aab_core #(
    parameter int SINGLE_ACCESS_RAM_BLOCKS = aab_pkg::SINGLE_ACCESS_RAM_BLOCKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // External memory ready line
    input wire logic ext_ready,
    // Engine activity
    output logic busy
);

    aab_pkg::aab_state_type s_r;
    aab_pkg::aab_state_type s_nxt;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic in_single_access_ram(input logic [15:0] a);
        logic [15:0] off;
        off = a - aab_pkg::SINGLE_ACCESS_RAM_BASE;
        in_single_access_ram = (a >= aab_pkg::SINGLE_ACCESS_RAM_BASE) &&
            ((off >> aab_pkg::SINGLE_ACCESS_RAM_BLK_SHIFT) < 16'(SINGLE_ACCESS_RAM_BLOCKS));
    endfunction

    function automatic logic [15:0] blk_of(input logic [15:0] a);
        blk_of = (a - aab_pkg::SINGLE_ACCESS_RAM_BASE) >> aab_pkg::SINGLE_ACCESS_RAM_BLK_SHIFT;
    endfunction

    logic accept;
    logic stretch;
    logic [15:0] pws;
    logic [15:0] mws;
    assign accept = hsel && htrans[1] && hready;
    // Ready may stretch any external cycle, data or program fetch alike.
    assign stretch = (s_r.kind != aab_pkg::KIND_ABS) || s_r.code_ext;
    assign mws = 16'(s_r.ws);
    assign pws = s_r.code_ext ? mws : 16'h0000;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0] wd;
        logic wr;
        logic [7:0] repeat_single_op;
        logic [15:0] base;
        wd = hwdata;
        wr = 1'b0;
        repeat_single_op = hwdata[aab_pkg::CMD_RPT_LSB +: 8];
        base = 16'h0001;
        s_nxt = s_r;
        s_nxt.done_abs = 1'b0;
        s_nxt.done_ext = 1'b0;
        s_nxt.hreadyout = 1'b1;
        s_nxt.hresp = 1'b0;

        // Data phase of a write. Only the probe may change while busy, so
        // an operation always sees the operands it was started with.
        if (s_r.dp_valid && s_r.dp_write) begin
            wr = 1'b1;
        end
        if (wr && s_r.dp_addr == aab_pkg::OFF_PROBE) begin
            s_nxt.probe = wd;
            s_nxt.pa_in = in_single_access_ram(wd[15:0]);
            s_nxt.pb_in = in_single_access_ram(wd[31:16]);
            // Two accesses collide only inside one block.
            s_nxt.conflict = in_single_access_ram(wd[15:0]) && in_single_access_ram(wd[31:16]) &&
                (blk_of(wd[15:0]) == blk_of(wd[31:16]));
        end else if (wr && s_r.eng == aab_pkg::ENG_RUN) begin
            s_nxt.refused = 1'b1;
        end else if (wr && s_r.dp_addr == aab_pkg::OFF_CTRL) begin
            s_nxt.saturate_on_overflow_mode = wd[aab_pkg::CTRL_OVM_BIT];
            s_nxt.sign_extend_mode = wd[aab_pkg::CTRL_SXM_BIT];
            s_nxt.ws = wd[aab_pkg::CTRL_WS_LSB +: aab_pkg::WS_W];
        end else if (wr && s_r.dp_addr == aab_pkg::OFF_ACC) begin
            s_nxt.acc = wd;
        end else if (wr && s_r.dp_addr == aab_pkg::OFF_PC) begin
            s_nxt.pc = wd[15:0];
        end else if (wr && s_r.dp_addr == aab_pkg::OFF_STATUS) begin
            s_nxt.carry = wd[aab_pkg::STAT_C_BIT];
            if (wd[aab_pkg::STAT_OV_BIT]) begin
                s_nxt.ov = 1'b0;
            end
            if (wd[aab_pkg::STAT_REFUSED_BIT]) begin
                s_nxt.refused = 1'b0;
            end
            if (wd[aab_pkg::STAT_BADOP_BIT]) begin
                s_nxt.badop = 1'b0;
            end
        end else if (wr && s_r.dp_addr == aab_pkg::OFF_CMD) begin
            // One flag covers every fetch of the operation, so the instructions
            // that follow are taken to come from the same section.
            s_nxt.code_ext = wd[aab_pkg::CMD_CODE_EXT_BIT];
            s_nxt.elapsed = 16'h0000;
            s_nxt.waits = 16'h0000;
            s_nxt.src = s_r.acc;
            s_nxt.src_pc = s_r.pc;
            if (wd[aab_pkg::CMD_READ_BIT]) begin
                s_nxt.kind = aab_pkg::KIND_READ;
                s_nxt.cnt = aab_pkg::EXT_READ_BASE + mws;
                s_nxt.turn_write = 1'b0;
                s_nxt.eng = aab_pkg::ENG_RUN;
            end else if (wd[aab_pkg::CMD_WRITE_BIT]) begin
                s_nxt.kind = aab_pkg::KIND_WRITE;
                s_nxt.turn_write = (s_r.ws == '0) && s_r.last_was_read;
                if (s_r.ws != '0) begin
                    s_nxt.cnt = 16'h0001 + mws;
                end else if (s_r.last_was_read) begin
                    s_nxt.cnt = aab_pkg::EXT_WRITE_TURN;
                end else begin
                    s_nxt.cnt = aab_pkg::EXT_WRITE_BASE;
                end
                s_nxt.eng = aab_pkg::ENG_RUN;
            end else if (wd[15:0] == aab_pkg::ABS_OPCODE) begin
                // A repeat below the pipeline depth runs as a single op.
                if (repeat_single_op >= aab_pkg::RPT_MIN) begin
                    base = 16'(repeat_single_op);
                end
                s_nxt.kind = aab_pkg::KIND_ABS;
                s_nxt.cnt = base + (wd[aab_pkg::CMD_CODE_EXT_BIT] ? mws : 16'h0000);
                s_nxt.turn_write = 1'b0;
                s_nxt.eng = aab_pkg::ENG_RUN;
            end else begin
                s_nxt.badop = 1'b1;
            end
        end

        // Engine: one count per machine cycle, ready stretches the last one of an external data access or fetch.
        case (s_r.eng)
            aab_pkg::ENG_RUN: begin
                if (s_r.cnt > 16'h0001) begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                    s_nxt.elapsed = s_r.elapsed + 16'h0001;
                end else if (stretch && !ext_ready) begin
                    s_nxt.waits = s_r.waits + 16'h0001;
                    s_nxt.elapsed = s_r.elapsed + 16'h0001;
                end else begin
                    s_nxt.eng = aab_pkg::ENG_IDLE;
                    s_nxt.last_cycles = s_r.elapsed + 16'h0001;
                    s_nxt.last_waits = s_r.waits;
                    s_nxt.last_was_read = (s_r.kind == aab_pkg::KIND_READ);
                    if (s_r.kind == aab_pkg::KIND_ABS) begin
                        s_nxt.done_abs = 1'b1;
                        s_nxt.pc = s_r.pc + 16'h0001;
                        s_nxt.carry = 1'b0;
                        if (s_r.acc == aab_pkg::ACC_MOST_NEG) begin
                            s_nxt.ov = 1'b1;
                            s_nxt.acc = s_r.saturate_on_overflow_mode ? aab_pkg::ACC_MOST_POS
                                : aab_pkg::ACC_MOST_NEG;
                        end else if (s_r.acc[31]) begin
                            s_nxt.acc = ~s_r.acc + 32'h0000_0001;
                        end else begin
                            s_nxt.acc = s_r.acc;
                        end
                    end else begin
                        s_nxt.done_ext = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // Address phase: capture, and prepare read data for the data phase.
        s_nxt.dp_valid = accept && (haddr[31:8] == 24'h00_0000) &&
            (hsize == aab_pkg::HSIZE_WORD);
        s_nxt.dp_write = hwrite;
        s_nxt.dp_addr = haddr[7:0];
        s_nxt.hrdata = 32'h0000_0000;
        if (accept && !hwrite && haddr[31:8] == 24'h00_0000) begin
            if (haddr[7:0] == aab_pkg::OFF_CTRL) begin
                s_nxt.hrdata[aab_pkg::CTRL_OVM_BIT] = s_r.saturate_on_overflow_mode;
                s_nxt.hrdata[aab_pkg::CTRL_SXM_BIT] = s_r.sign_extend_mode;
                s_nxt.hrdata[aab_pkg::CTRL_WS_LSB +: aab_pkg::WS_W] = s_r.ws;
            end else if (haddr[7:0] == aab_pkg::OFF_ACC) begin
                s_nxt.hrdata = s_r.acc;
            end else if (haddr[7:0] == aab_pkg::OFF_STATUS) begin
                s_nxt.hrdata[aab_pkg::STAT_C_BIT] = s_r.carry;
                s_nxt.hrdata[aab_pkg::STAT_OV_BIT] = s_r.ov;
                s_nxt.hrdata[aab_pkg::STAT_BUSY_BIT] = s_r.eng[1];
                s_nxt.hrdata[aab_pkg::STAT_REFUSED_BIT] = s_r.refused;
                s_nxt.hrdata[aab_pkg::STAT_BADOP_BIT] = s_r.badop;
                s_nxt.hrdata[aab_pkg::STAT_PA_IN_BIT] = s_r.pa_in;
                s_nxt.hrdata[aab_pkg::STAT_PB_IN_BIT] = s_r.pb_in;
                s_nxt.hrdata[aab_pkg::STAT_CONFLICT_BIT] = s_r.conflict;
            end else if (haddr[7:0] == aab_pkg::OFF_PC) begin
                s_nxt.hrdata[15:0] = s_r.pc;
            end else if (haddr[7:0] == aab_pkg::OFF_CYCLES) begin
                s_nxt.hrdata = {s_r.last_waits, s_r.last_cycles};
            end else if (haddr[7:0] == aab_pkg::OFF_PROBE) begin
                s_nxt.hrdata = s_r.probe;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.eng <= aab_pkg::ENG_IDLE;
            s_r.hreadyout <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.hrdata;
    assign hreadyout = s_r.hreadyout;
    assign hresp = s_r.hresp;
    assign busy = s_r.eng[1];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    abs_keep_pos_a: assert property (s_r.done_abs && !s_r.src[31] |-> s_r.acc == s_r.src)
        else $error("non-negative accumulator changed by absolute value");
    abs_negate_a: assert property (s_r.done_abs && s_r.src[31] &&
        s_r.src != aab_pkg::ACC_MOST_NEG |-> s_r.acc == 32'(~s_r.src + 32'h1))
        else $error("negative accumulator not negated");
    abs_carry_a: assert property (s_r.done_abs |-> !s_r.carry)
        else $error("carry not cleared by absolute value");
    abs_min_a: assert property (s_r.done_abs && s_r.src == aab_pkg::ACC_MOST_NEG |->
        s_r.acc == (s_r.saturate_on_overflow_mode ? aab_pkg::ACC_MOST_POS : aab_pkg::ACC_MOST_NEG))
        else $error("most negative value handled wrongly");
    abs_sat_a: assert property (s_r.done_abs && s_r.saturate_on_overflow_mode && s_r.src[31] |->
        !s_r.acc[31])
        else $error("saturation left a negative result");
    abs_ov_a: assert property (s_r.done_abs && s_r.src == aab_pkg::ACC_MOST_NEG |-> s_r.ov)
        else $error("overflow flag not set");
    abs_pc_a: assert property (s_r.done_abs |-> s_r.pc == 16'(s_r.src_pc + 16'h1))
        else $error("program counter not advanced by one");
    abs_cost_a: assert property (s_r.done_abs && !s_r.code_ext |->
        s_r.last_cycles == 16'h0001 || s_r.last_cycles >= 16'(aab_pkg::RPT_MIN))
        else $error("absolute value cost wrong");
    ext_read_a: assert property (s_r.done_ext && s_r.last_was_read |->
        s_r.last_cycles == 16'(16'h1 + mws + s_r.last_waits))
        else $error("external read cost wrong");
    ext_write_a: assert property (s_r.done_ext && !s_r.last_was_read && s_r.ws == '0 |->
        s_r.last_cycles == 16'((s_r.turn_write ? 16'h3 : 16'h2) + s_r.last_waits))
        else $error("external write cost wrong");
    ext_ws_a: assert property (s_r.done_ext && s_r.ws != '0 && s_r.last_waits == 16'h0 |->
        s_r.last_cycles == 16'(16'h1 + mws))
        else $error("wait-state generator cost wrong");
    run_bound_a: assert property ($rose(busy) && s_r.cnt == 16'h1 && !stretch |=> !busy)
        else $error("single-cycle operation overran");
    probe_blk_a: assert property (s_r.conflict |-> s_r.pa_in && s_r.pb_in &&
        blk_of(s_r.probe[15:0]) == blk_of(s_r.probe[31:16]))
        else $error("block conflict reported wrongly");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus response not zero-wait OKAY");

    // Cost checks. The fetch conflict of the operation itself is part of its count,
    // so an externally fetched operation never costs less than one cycle plus waits.
    abs_fetch_a: assert property (s_r.done_abs |->
        s_r.last_cycles >= 16'(16'h1 + pws + s_r.last_waits))
        else $error("absolute value cost below its fetch cost");
    done_idle_a: assert property (s_r.done_abs || s_r.done_ext |-> !busy)
        else $error("engine still busy after completion");
    done_abs_one_a: assert property (s_r.done_abs |=> !s_r.done_abs)
        else $error("completion pulse held too long");
    done_ext_one_a: assert property (s_r.done_ext |=> !s_r.done_ext)
        else $error("external completion pulse held too long");
    cnt_live_a: assert property (busy |-> s_r.cnt != 16'h0)
        else $error("running engine with an empty count");
    turn_kind_a: assert property (s_r.turn_write |-> s_r.kind == aab_pkg::KIND_WRITE)
        else $error("turnaround cost applied to a non-write");

    // Register protection. A write that lands while the engine runs must leave the
    // operands alone, otherwise a result would mix old and new inputs.
    refuse_busy_a: assert property (s_r.dp_valid && s_r.dp_write && busy &&
        s_r.dp_addr != aab_pkg::OFF_PROBE |=> s_r.refused)
        else $error("write during an operation not refused");
    badop_set_a: assert property (s_r.dp_valid && s_r.dp_write && !busy &&
        s_r.dp_addr == aab_pkg::OFF_CMD && hwdata[17:16] == 2'b00 &&
        hwdata[15:0] != aab_pkg::ABS_OPCODE |=> s_r.badop)
        else $error("unknown command not flagged");
    read_start_a: assert property (s_r.dp_valid && s_r.dp_write && !busy &&
        s_r.dp_addr == aab_pkg::OFF_CMD && hwdata[16] |=> busy)
        else $error("external read did not start");
    carry_hold_a: assert property (!busy && !(s_r.dp_valid && s_r.dp_write) |=>
        $stable(s_r.carry))
        else $error("carry changed without a cause");
    pc_hold_a: assert property (!busy && !(s_r.dp_valid && s_r.dp_write) |=>
        $stable(s_r.pc))
        else $error("program counter changed without a cause");
    ov_rise_a: assert property ($rose(s_r.ov) |-> s_r.done_abs)
        else $error("overflow flag set outside an operation");
    acc_write_a: assert property ($changed(s_r.acc) && !s_r.done_abs |->
        $past(s_r.dp_valid) && $past(s_r.dp_write) && $past(s_r.dp_addr) == aab_pkg::OFF_ACC)
        else $error("accumulator changed without a cause");
    ws_write_a: assert property ($changed(s_r.ws) |->
        $past(s_r.dp_valid) && $past(s_r.dp_write) && $past(s_r.dp_addr) == aab_pkg::OFF_CTRL)
        else $error("wait-state count changed without a cause");
    ovm_write_a: assert property ($changed(s_r.saturate_on_overflow_mode) |->
        $past(s_r.dp_valid) && $past(s_r.dp_write) && $past(s_r.dp_addr) == aab_pkg::OFF_CTRL)
        else $error("saturation mode changed without a cause");
    read_idle_a: assert property (!$past(accept) |-> hrdata == 32'h0000_0000)
        else $error("read data outside its data phase");

    // Probe decode. Blocks are 2K words each, so the top of the RAM follows from
    // the block count; a part with fewer blocks only needs a smaller parameter.
    single_access_ram_lo_a: assert property (s_r.pa_in |-> s_r.probe[15:0] >= aab_pkg::SINGLE_ACCESS_RAM_BASE)
        else $error("probe address below single-access RAM");
    single_access_ram_hi_a: assert property (s_r.pb_in |-> s_r.probe[31:16] <
        16'(aab_pkg::SINGLE_ACCESS_RAM_BASE + (SINGLE_ACCESS_RAM_BLOCKS << aab_pkg::SINGLE_ACCESS_RAM_BLK_SHIFT)))
        else $error("probe address above single-access RAM");

    sat_cov: cover property (s_r.done_abs && s_r.saturate_on_overflow_mode && s_r.src == aab_pkg::ACC_MOST_NEG);
    neg_cov: cover property (s_r.done_abs && s_r.src[31]);
    turn_cov: cover property (s_r.done_ext && s_r.turn_write);
    ready_cov: cover property (s_r.done_ext && s_r.last_waits != 16'h0);
    rpt_cov: cover property (s_r.done_abs && s_r.last_cycles >= 16'(aab_pkg::RPT_MIN));

endmodule // aab_core

// ==== dv/aab_ext_mem.sv ====
module aab_ext_mem (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Engine activity and requested low span
    input wire logic busy,
    input wire logic [7:0] low_len,
    // Ready line to the device
    output logic ext_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    assign cnt_nxt = busy ? cnt_r + 8'h01 : 8'h00;
    // Ready is held low for low_len cycles from the edge that starts an access.
    // Only low cycles that overlap the last counted cycle stretch the access.
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= 8'h00;
            ext_ready <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            ext_ready <= (cnt_nxt >= low_len);
        end
    end
endmodule // aab_ext_mem

// ==== dv/acc_abs_and_access_timing_tb_top.sv ====
module acc_abs_and_access_timing_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, hsel, hwrite, hreadyout, hresp, ext_ready, busy, rdy_s, prev_rd;
    logic [31:0] haddr, hwdata, hrdata, rd, rd_s;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] low_len;
    logic [15:0] pcv;
    int n_mismatch, samples_checked, ncyc;
    logic [31:0] corner [6] = '{32'h0, 32'h1234, 32'hFFFF_FFFF, 32'h7FFF_FFFF,
        32'h8000_0001, 32'h8000_0000};
    int tab [12][5] = '{'{1,0,0,0,0}, '{2,0,0,0,0}, '{2,0,0,0,0}, '{2,0,0,0,3},
        '{1,0,0,0,2}, '{1,3,0,0,0}, '{2,3,0,0,0}, '{2,2,0,0,2}, '{0,0,5,0,0},
        '{0,0,2,0,0}, '{0,2,0,1,1}, '{0,1,4,1,0}};
    logic [34:0] ptab [4] = '{{3'h7, 16'h0FFF, 16'h0800}, {3'h2, 16'h27FF, 16'h07FF},
        {3'h1, 16'h2800, 16'h1000}, {3'h3, 16'h1000, 16'h0FFF}};

    aab_core dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_ready(ext_ready),
        .busy(busy));
    aab_ext_mem mem (.clock(clock), .rst(rst), .busy(busy), .low_len(low_len),
        .ext_ready(ext_ready));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Mid-cycle samples give the values seen at the next rising edge without a race.
    always @(negedge clock) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end

    // ****************************************************************
    // Bus tasks and expectations
    // ****************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= aab_pkg::HSIZE_WORD;
        do @(posedge clock); while (rdy_s !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (rdy_s !== 1'b1);
        rd = rd_s;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task wait_idle;
        ncyc = 0;
        @(negedge clock);
        while (busy === 1'b1 && ncyc < 400) begin
            ncyc++;
            @(negedge clock);
        end
        @(posedge clock);
    endtask
    function automatic logic [31:0] abs_of(input logic [31:0] v, input logic saturate_on_overflow_mode);
        if (!v[31]) return v;
        if (v == aab_pkg::ACC_MOST_NEG) return saturate_on_overflow_mode ? aab_pkg::ACC_MOST_POS : v;
        return -v;
    endfunction
    function automatic int base_of(input int k, m, n, ext, pr);
        if (k == 0) return ((n >= 3) ? n : 1) + ((ext != 0) ? m : 0);
        if (k == 1) return 1 + m;
        if (m > 0) return m + 1;
        return pr ? 3 : 2;
    endfunction
    function automatic logic [31:0] cmd_of(input int k, n, ext);
        return {8'(n), 5'h00, ext != 0, k == 2, k == 1,
            (k == 0) ? aab_pkg::ABS_OPCODE : 16'h0000};
    endfunction
    task run(input logic [31:0] cmd, input int base, input int s);
        low_len <= 8'(base - 1 + s);
        wr(aab_pkg::OFF_CMD, cmd);
        wait_idle();
        chk(32'(ncyc), 32'(base + s));
        rdc(aab_pkg::OFF_CYCLES, {16'(s), 16'(base + s)});
        low_len <= 8'h00;
    endtask
    task op(input int k, m, n, ext, s);
        wr(aab_pkg::OFF_CTRL, 32'(m) << aab_pkg::CTRL_WS_LSB);
        run(cmd_of(k, n, ext), base_of(k, m, n, ext, prev_rd), s);
        prev_rd = (k == 1);
    endtask
    task absv(input logic [31:0] v, input logic saturate_on_overflow_mode);
        pcv = 16'($urandom);
        wr(aab_pkg::OFF_CTRL, {31'h0, saturate_on_overflow_mode});
        wr(aab_pkg::OFF_ACC, v);
        wr(aab_pkg::OFF_STATUS, 32'h3);
        wr(aab_pkg::OFF_PC, {16'h0, pcv});
        run(cmd_of(0, 0, 0), 1, 0);
        prev_rd = 1'b0;
        rdc(aab_pkg::OFF_ACC, abs_of(v, saturate_on_overflow_mode));
        rdc(aab_pkg::OFF_STATUS, {30'h0, v == aab_pkg::ACC_MOST_NEG, 1'b0});
        rdc(aab_pkg::OFF_PC, {16'h0, pcv + 16'h1});
    endtask
    task wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, low_len, prev_rd} = '0;
        hsize = aab_pkg::HSIZE_WORD;
        n_mismatch = 0;
        samples_checked = 0;
        void'($urandom(78188));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        @(posedge clock);
        for (int i = 0; i < 7; i++) rdc(32'(i * 4), 32'h0);
        wr(32'h100, 32'hFFFF_FFFF);
        rdc(32'h100, 32'h0);
        for (int i = 0; i < 12; i++) absv(corner[i / 2], i[0]);
        for (int i = 0; i < 20; i++) absv($urandom, 1'($urandom));
        for (int i = 0; i < 12; i++) op(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4]);
        for (int i = 0; i < 30; i++) begin
            automatic int k = $urandom % 3;
            automatic int e = $urandom % 2;
            op(k, $urandom % 16, $urandom % 7, e, (k == 0 && e == 0) ? 0 : $urandom % 5);
        end
        wr(aab_pkg::OFF_STATUS, 32'h1A);
        wr(aab_pkg::OFF_CTRL, 32'hF00);
        wr(aab_pkg::OFF_ACC, 32'h1234);
        low_len <= 8'd15;
        wr(aab_pkg::OFF_CMD, cmd_of(1, 0, 0));
        rdc(aab_pkg::OFF_STATUS, 32'h4);
        wr(aab_pkg::OFF_ACC, 32'h55);
        wait_idle();
        rdc(aab_pkg::OFF_STATUS, 32'h8);
        rdc(aab_pkg::OFF_ACC, 32'h1234);
        wr(aab_pkg::OFF_STATUS, 32'h8);
        wr(aab_pkg::OFF_CMD, 32'h1234);
        rdc(aab_pkg::OFF_STATUS, 32'h10);
        rdc(aab_pkg::OFF_CMD, 32'h0);
        wr(aab_pkg::OFF_STATUS, 32'h10);
        for (int i = 0; i < 4; i++) begin
            wr(aab_pkg::OFF_PROBE, ptab[i][31:0]);
            rdc(aab_pkg::OFF_STATUS, {21'h0, ptab[i][34:32], 8'h00});
        end
        wrap_up();
    end
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
endmodule // acc_abs_and_access_timing_tb_top
